/* rtl/tmc_clk_sel.sv */
// Counter clock-source selector: dividers, time-base strobe and external pin.
// Assumes high_clk_tick and time_base_clock are one-cycle strobes on core_clk.
`timescale 1ns/10ps
`default_nettype none
`include "tmc_consts.svh"
module tmc_clk_sel
  import tmc_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic ce,
  input  wire logic high_clk_tick,
  input  wire logic time_base_clock,
  input  wire logic timer_ext_clock_pin,
  tmc_tick_if.src   tk
);
  logic [1:0] sys_div;
  logic [5:0] h_div;
  logic       ext_s1;
  logic       ext_s2;
  logic       ext_s3;

  // System clock divider
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) sys_div <= 2'h0;
    else if (ce) sys_div <= sys_div + 2'h1;
  end

  // High clock divider, advanced by its strobe
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) h_div <= 6'h00;
    else if (ce && high_clk_tick) h_div <= h_div + 6'h01;
  end

  // Two-stage synchroniser plus one edge-history stage
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_s1 <= 1'b0;
      ext_s2 <= 1'b0;
      ext_s3 <= 1'b0;
    end else if (ce) begin
      ext_s1 <= timer_ext_clock_pin;
      ext_s2 <= ext_s1;
      ext_s3 <= ext_s2;
    end
  end

  // Source mux; the pin reaches the counter only when chosen
  always_comb begin
    unique case (tk.clk_select)
      TMC_CK_SYS4:  tk.tick = (sys_div == 2'(`TMC_DIV_SYS - 1));
      TMC_CK_SYS:   tk.tick = 1'b1;
      TMC_CK_H16:   tk.tick = high_clk_tick && (h_div[3:0] == 4'(`TMC_DIV_H_LO - 1));
      TMC_CK_H64:   tk.tick = high_clk_tick && (h_div == 6'(`TMC_DIV_H_HI - 1));
      TMC_CK_TBC:   tk.tick = time_base_clock;
      TMC_CK_RSV:   tk.tick = 1'b0;                      // Disconnected
      TMC_CK_EXT_R: tk.tick = ext_s2 && !ext_s3;         // One per rising edge
      TMC_CK_EXT_F: tk.tick = !ext_s2 && ext_s3;         // One per falling edge
    endcase
  end
endmodule
`default_nettype wire

/* rtl/tmc_consts.svh */
// Constants of the timer block: register offsets, fields, reset values, dividers.
// Assumes byte addresses on an APB bus with 32-bit data, one register per word.
`ifndef TMC_CONSTS_SVH
`define TMC_CONSTS_SVH

// Register byte offsets
`define TMC_OFF_CTRL0   8'h00
`define TMC_OFF_CTRL1   8'h04
`define TMC_OFF_CNT_L   8'h08
`define TMC_OFF_CNT_H   8'h0C
`define TMC_OFF_CMPA_L  8'h10
`define TMC_OFF_CMPA_H  8'h14
`define TMC_OFF_CMPB_L  8'h18
`define TMC_OFF_CMPB_H  8'h1C
`define TMC_OFF_CMPP_L  8'h20
`define TMC_OFF_CMPP_H  8'h24
`define TMC_OFF_PINFN0  8'h28
`define TMC_OFF_PINFN1  8'h2C
`define TMC_OFF_OUTINV  8'h30

// Control 0 fields
`define TMC_C0_PAUSE    7
`define TMC_C0_CKS_HI   6
`define TMC_C0_CKS_LO   4
`define TMC_C0_ON       3
// Control 1 fields
`define TMC_C1_MODE_HI  7
`define TMC_C1_MODE_LO  6
`define TMC_C1_IO_HI    5
`define TMC_C1_IO_LO    4
`define TMC_C1_OC       3
`define TMC_C1_POL      2
`define TMC_C1_CCLR     0
`define TMC_C1_MASK     8'hFD

// Pin-function enables, reset values and implemented bits
`define TMC_PINFN0_RST  8'h91
`define TMC_PINFN0_MASK 8'hF3
`define TMC_PINFN1_RST  8'h01
`define TMC_PINFN1_MASK 8'h03
`define TMC_OUTINV_MASK 8'h03
`define TMC_PF0_ENH_A   7
`define TMC_PF0_ENH_B0  4
`define TMC_PF0_CMP_O1  1
`define TMC_PF0_CMP_O0  0
`define TMC_PF1_STD_O1  1
`define TMC_PF1_STD_O0  0

// Clock-source dividers
`define TMC_DIV_SYS     4
`define TMC_DIV_H_LO    16
`define TMC_DIV_H_HI    64

`endif

/* rtl/tmc_pkg.sv */
// Types shared by the timer block files.
// Assumes nothing beyond a SystemVerilog compiler.
package tmc_pkg;
  // Counter clock-source codes
  typedef enum logic [2:0] {
    TMC_CK_SYS4  = 3'h0,
    TMC_CK_SYS   = 3'h1,
    TMC_CK_H16   = 3'h2,
    TMC_CK_H64   = 3'h3,
    TMC_CK_TBC   = 3'h4,
    TMC_CK_RSV   = 3'h5,
    TMC_CK_EXT_R = 3'h6,
    TMC_CK_EXT_F = 3'h7
  } tmc_clk_sel_t;
  // Operating modes
  typedef enum logic [1:0] {
    TMC_M_CMP = 2'h0, TMC_M_UND = 2'h1, TMC_M_PWM = 2'h2, TMC_M_CNT = 2'h3
  } tmc_mode_t;
  // Output action on compare match
  typedef enum logic [1:0] {
    TMC_IO_NONE = 2'h0, TMC_IO_LOW = 2'h1, TMC_IO_HIGH = 2'h2, TMC_IO_TGL = 2'h3
  } tmc_io_t;
endpackage

/* rtl/tmc_tick_if.sv */
// Carries the clock-source choice and the resulting count strobe.
// Assumes both ends run on core_clk.
`timescale 1ns/10ps
`default_nettype none
interface tmc_tick_if;
  import tmc_pkg::*;
  tmc_clk_sel_t clk_select;
  logic         tick;
  modport src  (input clk_select, output tick);
  modport sink (output clk_select, input tick);
endinterface
`default_nettype wire

/* rtl/tmc_timer.sv */
// Timer channel with byte-buffered counter/compare access and pin-function enables.
// Assumes an APB master on core_clk; pins are synchronous except the external clock.
`timescale 1ns/10ps
`default_nettype none
`include "tmc_consts.svh"
// Operation
// - Counter compared to comparators, match raises interrupt
// - Counter source is selectable among four kinds
// - Reserved clock code stops the counter
// - External pin counts rising or falling edges
// - Compact/standard: interrupts on A and P
// - Enhanced: interrupts on A, B and P
// - External pin used only when selected
// - Match sets, clears or toggles output
// - PWM uses the same output pin
// - Pin enable bit gives pin to timer
// - First pin register layout, bits 3-2 zero
// - Second pin register: bits 7-2 read zero
// - Output pair inversion from port data bits
// - Counter and compares split into two bytes
// - Low bytes pass through one shared buffer
// - High write copies buffer into low byte
// - High read latches low byte into buffer
// - Clock-select code table
module tmc_timer
  import tmc_pkg::*;
#(
  parameter int W    = 10,
  parameter int KIND = 0
) (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        high_clk_tick,
  input  wire logic        time_base_clock,
  input  wire logic        timer_ext_clock_pin,
  output var  logic        irq_match_a,
  output var  logic        irq_match_b,
  output var  logic        irq_match_p,
  output var  logic [1:0]  timer_output_pin,
  output var  logic [1:0]  timer_output_oe,
  output var  logic [7:0]  pin_function_0,
  output var  logic [7:0]  pin_function_1
);
  localparam int  HW    = W - 8;
  localparam bit  HAS_B = (KIND == 2);

  tmc_tick_if tk ();

  logic [7:0]   ctrl0;
  logic [7:0]   ctrl1;
  logic [7:0]   out_invert;
  logic [W-1:0] cnt;
  logic [W-1:0] cmp_a;
  logic [W-1:0] cmp_b;
  logic [W-1:0] cmp_p;
  logic [7:0]   byte_buf;
  logic [7:0]   snap_low;
  logic         on_q;
  logic         tp_level;
  logic         wr_acc;
  logic         rd_acc;
  logic         setup;
  logic         adv;
  logic         on_rise;
  logic         hit_a;
  logic         hit_b;
  logic         hit_p;
  logic         clr_hit;
  logic         addr_ok;
  logic [7:0]   rd_val;
  logic [7:0]   low_of;
  logic         next_level;
  tmc_mode_t    mode;
  tmc_io_t      io_act;

  // Widen a high part to a byte, upper bits read as zero
  function automatic logic [7:0] hi_byte(input logic [W-1:0] v);
    hi_byte = 8'(v[W-1:8]);
  endfunction

  // Enable bit for this timer's output pin k
  function automatic logic pin_en(input logic [7:0] f0, input logic [7:0] f1,
                                  input int k);
    if (KIND == 2) pin_en = (k == 0) ? f0[`TMC_PF0_ENH_A] : f0[`TMC_PF0_ENH_B0];
    else if (KIND == 1) pin_en = f1[k];
    else pin_en = f0[k];
  endfunction

  tmc_clk_sel u_clk_sel (
    .core_clk            (core_clk),
    .rst_n               (rst_n),
    .ce                  (ce),
    .high_clk_tick       (high_clk_tick),
    .time_base_clock     (time_base_clock),
    .timer_ext_clock_pin (timer_ext_clock_pin),
    .tk                  (tk.src)
  );

  // Field decode and bus phases
  assign tk.clk_select = tmc_clk_sel_t'(ctrl0[`TMC_C0_CKS_HI:`TMC_C0_CKS_LO]);
  assign mode     = tmc_mode_t'(ctrl1[`TMC_C1_MODE_HI:`TMC_C1_MODE_LO]);
  assign io_act   = tmc_io_t'(ctrl1[`TMC_C1_IO_HI:`TMC_C1_IO_LO]);
  assign pready   = ce;                     // Zero wait states; stalls while frozen
  assign setup    = ce && psel && !penable;
  assign wr_acc   = ce && psel && penable && pwrite && addr_ok;
  assign rd_acc   = ce && psel && penable && !pwrite && addr_ok;
  assign pslverr  = psel && penable && !addr_ok;
  assign on_rise  = ctrl0[`TMC_C0_ON] && !on_q;
  assign adv      = ce && ctrl0[`TMC_C0_ON] && !ctrl0[`TMC_C0_PAUSE] && tk.tick;

  // Comparators; a zero period means run to full count
  assign hit_a   = (cnt == cmp_a);
  assign hit_b   = HAS_B && (cnt == cmp_b);
  assign hit_p   = (cmp_p == '0) ? (&cnt) : (cnt == cmp_p);
  assign clr_hit = ctrl1[`TMC_C1_CCLR] ? hit_a : hit_p;

  // Address decode and read data for the setup phase
  always_comb begin
    addr_ok = 1'b1;
    rd_val  = 8'h00;
    low_of  = 8'h00;
    unique case (paddr)
      `TMC_OFF_CTRL0:  rd_val = ctrl0;
      `TMC_OFF_CTRL1:  rd_val = ctrl1;
      `TMC_OFF_CNT_L:  rd_val = byte_buf;
      `TMC_OFF_CNT_H:  begin
        rd_val = hi_byte(cnt);
        low_of = cnt[7:0];
      end
      `TMC_OFF_CMPA_L: rd_val = byte_buf;
      `TMC_OFF_CMPA_H: begin
        rd_val = hi_byte(cmp_a);
        low_of = cmp_a[7:0];
      end
      `TMC_OFF_CMPB_L: begin
        rd_val  = byte_buf;
        addr_ok = HAS_B;
      end
      `TMC_OFF_CMPB_H: begin
        rd_val  = hi_byte(cmp_b);
        low_of  = cmp_b[7:0];
        addr_ok = HAS_B;
      end
      `TMC_OFF_CMPP_L: rd_val = byte_buf;
      `TMC_OFF_CMPP_H: begin
        rd_val = hi_byte(cmp_p);
        low_of = cmp_p[7:0];
      end
      `TMC_OFF_PINFN0: rd_val = pin_function_0;
      `TMC_OFF_PINFN1: rd_val = pin_function_1;
      `TMC_OFF_OUTINV: rd_val = out_invert;
      default:         addr_ok = 1'b0;
    endcase
  end

  // Read data and low-byte snapshot taken together in setup, so a high read
  // and the low byte it latches come from the same counter value
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata   <= 32'h0000_0000;
      snap_low <= 8'h00;
    end else if (setup) begin
      prdata   <= {24'h00_0000, rd_val};
      snap_low <= low_of;
    end
  end

  // Shared byte buffer: compare low writes fill it, high reads refill it
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) byte_buf <= 8'h00;
    else if (wr_acc && (paddr == `TMC_OFF_CMPA_L || paddr == `TMC_OFF_CMPB_L
                     || paddr == `TMC_OFF_CMPP_L)) byte_buf <= pwdata[7:0];
    else if (rd_acc && (paddr == `TMC_OFF_CNT_H || paddr == `TMC_OFF_CMPA_H
                     || paddr == `TMC_OFF_CMPB_H || paddr == `TMC_OFF_CMPP_H))
      byte_buf <= snap_low;
  end

  // Compare registers load both halves on a high write
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmp_a <= '0;
      cmp_b <= '0;
      cmp_p <= '0;
    end else if (wr_acc) begin
      if (paddr == `TMC_OFF_CMPA_H) cmp_a <= {pwdata[HW-1:0], byte_buf};
      if (paddr == `TMC_OFF_CMPB_H) cmp_b <= {pwdata[HW-1:0], byte_buf};
      if (paddr == `TMC_OFF_CMPP_H) cmp_p <= {pwdata[HW-1:0], byte_buf};
    end
  end

  // Control registers and pin-function enables
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl0          <= 8'h00;
      ctrl1          <= 8'h00;
      out_invert     <= 8'h00;
      pin_function_0 <= `TMC_PINFN0_RST;
      pin_function_1 <= `TMC_PINFN1_RST;
    end else if (wr_acc) begin
      unique case (paddr)
        `TMC_OFF_CTRL0:  ctrl0          <= pwdata[7:0];
        `TMC_OFF_CTRL1:  ctrl1          <= pwdata[7:0] & `TMC_C1_MASK;
        `TMC_OFF_OUTINV: out_invert     <= pwdata[7:0] & `TMC_OUTINV_MASK;
        `TMC_OFF_PINFN0: pin_function_0 <= pwdata[7:0] & `TMC_PINFN0_MASK;
        `TMC_OFF_PINFN1: pin_function_1 <= pwdata[7:0] & `TMC_PINFN1_MASK;
        default:         ;
      endcase
    end
  end

  // On-bit history for the off-to-on counter clear
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) on_q <= 1'b0;
    else if (ce) on_q <= ctrl0[`TMC_C0_ON];
  end

  // Free-running counter, cleared by switch-on or by the chosen match
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) cnt <= '0;
    else if (ce && on_rise) cnt <= '0;
    else if (adv) cnt <= clr_hit ? '0 : cnt + W'(1);
  end

  // Match interrupts, one-cycle pulses; B exists only on enhanced
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_match_a <= 1'b0;
      irq_match_b <= 1'b0;
      irq_match_p <= 1'b0;
    end else if (ce) begin
      irq_match_a <= adv && hit_a;
      irq_match_b <= adv && hit_b;
      irq_match_p <= adv && hit_p;
    end
  end

  // Waveform level: match actions in compare mode, duty in PWM
  always_comb begin
    next_level = tp_level;
    if (on_rise) next_level = ctrl1[`TMC_C1_OC];
    else if (mode == TMC_M_CMP && adv && hit_a) begin
      unique case (io_act)
        TMC_IO_NONE: next_level = tp_level;
        TMC_IO_LOW:  next_level = 1'b0;
        TMC_IO_HIGH: next_level = 1'b1;
        TMC_IO_TGL:  next_level = !tp_level;
      endcase
    end else if (mode == TMC_M_PWM && ctrl0[`TMC_C0_ON])
      next_level = (cnt < cmp_a) ? ctrl1[`TMC_C1_OC] : !ctrl1[`TMC_C1_OC];
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) tp_level <= 1'b0;
    else if (ce) tp_level <= next_level;
  end

  // Pin pair: polarity plus per-pin inversion bit; enable hands the pin over
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_output_pin <= 2'h0;
      timer_output_oe  <= 2'h0;
    end else if (ce) begin
      for (int k = 0; k < 2; k++) begin
        timer_output_pin[k] <= tp_level ^ ctrl1[`TMC_C1_POL] ^ out_invert[k];
        timer_output_oe[k]  <= pin_en(pin_function_0, pin_function_1, k);
      end
    end
  end

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_match_a_irq: assert property (adv && hit_a |=> irq_match_a)
    else $error("compare A match gave no interrupt");
  a_match_p_irq: assert property (adv && hit_p |=> irq_match_p)
    else $error("compare P match gave no interrupt");
  a_match_b_irq: assert property (irq_match_b |-> HAS_B && $past(cnt) == cmp_b)
    else $error("B interrupt without a B match");
  a_reserved_hold: assert property (ce && tk.clk_select == TMC_CK_RSV && !on_rise
                                    |=> cnt == $past(cnt))
    else $error("counter moved with reserved clock");
  a_reserved_quiet: assert property (ce && tk.clk_select == TMC_CK_RSV
                                     |=> !irq_match_a && !irq_match_p)
    else $error("interrupt raised with reserved clock");
  a_p_match_clear: assert property (adv && hit_p && !ctrl1[`TMC_C1_CCLR]
                                    |=> cnt == '0)
    else $error("period match did not clear counter");
  a_toggle_out: assert property (ce && !on_rise && mode == TMC_M_CMP
                                 && io_act == TMC_IO_TGL && adv && hit_a
                                 |=> tp_level != $past(tp_level))
    else $error("output did not toggle on match");
  a_pwm_low: assert property (ce && mode == TMC_M_PWM && ctrl0[`TMC_C0_ON] && !on_rise
                              && cnt >= cmp_a |=> tp_level == !$past(ctrl1[`TMC_C1_OC]))
    else $error("PWM level wrong past the duty point");
  a_pin_gate: assert property (ce && !pin_en(pin_function_0, pin_function_1, 0)
                               |=> !timer_output_oe[0])
    else $error("pin driven without enable");
  a_oe_follow: assert property (timer_output_oe[1]
                                |-> $past(pin_en(pin_function_0, pin_function_1, 1)))
    else $error("second pin driven without enable");
  a_rsv_zero: assert property (pin_function_0[3:2] == 2'h0
                               && pin_function_1[7:2] == 6'h00)
    else $error("reserved pin-control bits set");
  a_low_write_buf: assert property (wr_acc && paddr == `TMC_OFF_CMPA_L
                                    |=> byte_buf == $past(pwdata[7:0])
                                        && cmp_a == $past(cmp_a))
    else $error("low write leaked past buffer");
  a_high_write_copy: assert property (wr_acc && paddr == `TMC_OFF_CMPA_H
                                      |=> cmp_a[7:0] == $past(byte_buf))
    else $error("high write did not copy buffer");
  a_high_write_hi: assert property (wr_acc && paddr == `TMC_OFF_CMPA_H
                                    |=> cmp_a[W-1:8] == $past(pwdata[HW-1:0]))
    else $error("high write did not load high part");
  a_high_read_latch: assert property (setup && paddr == `TMC_OFF_CNT_H ##1 rd_acc
                                      |=> byte_buf == $past(cnt[7:0], 2))
    else $error("high read did not latch low byte");
  a_low_read_buf: assert property (setup && paddr == `TMC_OFF_CNT_L
                                   |=> prdata[7:0] == $past(byte_buf))
    else $error("low read bypassed the buffer");

  c_match_clear: cover property (adv && clr_hit ##1 cnt == '0);
  c_ext_count: cover property (tk.clk_select == TMC_CK_EXT_F && adv);
  c_pair_read: cover property (rd_acc && paddr == `TMC_OFF_CNT_H
                               ##[1:8] rd_acc && paddr == `TMC_OFF_CNT_L);
  c_pwm_rise: cover property (mode == TMC_M_PWM && $rose(tp_level));
endmodule
`default_nettype wire

/* sim/timer_module_common_io_bench.sv */
// Self-checking bench of the timer block: APB register access, clock sources, outputs.
// Assumes tmc_timer with W=10, KIND=2 and the far-side model tmc_ext_src.
`timescale 1ns/10ps
`default_nettype none
`include "tmc_consts.svh"
module timer_module_common_io_bench
  import tmc_pkg::*;
;
  typedef struct { logic [2:0] cks; int gap; } tmc_row_t;
  logic        core_clk, rst_n, ce, psel, penable, pwrite;
  logic [7:0]  paddr, pf0, pf1;
  logic [31:0] pwdata, prdata, q;
  logic        pready, pslverr, high_clk_tick, time_base_clock, ext_pin, e;
  logic        irq_a, irq_b, irq_p;
  logic [1:0]  tpin, toe, pad;
  int          bad_count, cmp_count, cyc, n, i, hi;
  // Counter runs 0..5 with clear on A, so one period is six source ticks
  tmc_row_t    rows [6] = '{'{3'h0, 24}, '{3'h1, 6}, '{3'h2, 192}, '{3'h3, 768},
                            '{3'h4, 30}, '{3'h5, 0}};

  tmc_timer #(.W(10), .KIND(2)) dut (.core_clk(core_clk), .rst_n(rst_n), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .high_clk_tick(high_clk_tick),
    .time_base_clock(time_base_clock), .timer_ext_clock_pin(ext_pin),
    .irq_match_a(irq_a), .irq_match_b(irq_b), .irq_match_p(irq_p),
    .timer_output_pin(tpin), .timer_output_oe(toe),
    .pin_function_0(pf0), .pin_function_1(pf1));

  tmc_ext_src src (.core_clk(core_clk), .rst_n(rst_n), .high_clk_tick(high_clk_tick),
    .time_base_clock(time_base_clock), .timer_ext_clock_pin(ext_pin),
    .timer_output_pin(tpin), .timer_output_oe(toe), .pad_level(pad));

  // 200 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Hang guard, well above the longest sequence
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      bad_count++;
      results();
    end
  end

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_pin(input logic [1:0] got, input logic [1:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk_val(q, exp);
  endtask

  // Low byte first, then high byte, as the shared buffer needs
  task automatic set_cmp(input logic [7:0] a, input logic [9:0] v);
    apb(1'b1, a, {24'h0, v[7:0]});
    apb(1'b1, a + 8'h04, {30'h0, v[9:8]});
  endtask

  // Cycles until the chosen match pulse is seen; 0 if none within the bound
  task automatic gap(input int w, input int bound, output int r);
    int t;
    logic s;
    r = 0;
    for (t = 0; t < bound && r == 0; t++) begin
      @(posedge core_clk);
      s = (w == 0) ? irq_a : (w == 1) ? irq_b : irq_p;
      if (s === 1'b1) r = t + 1;
    end
  endtask

  initial begin
    {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    ce = 1'b1;
    bad_count = 0;
    cmp_count = 0;
    cyc = 0;
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    // Reset values of the pin-function registers and their copies
    chk_val({24'h0, pf0}, `TMC_PINFN0_RST);
    chk_val({24'h0, pf1}, `TMC_PINFN1_RST);
    rdc(`TMC_OFF_PINFN0, 32'h91);
    rdc(`TMC_OFF_PINFN1, 32'h01);
    chk_pin(toe, 2'b11);
    apb(1'b1, `TMC_OFF_PINFN0, 32'hFF);
    rdc(`TMC_OFF_PINFN0, 32'hF3);
    apb(1'b1, `TMC_OFF_PINFN1, 32'hFF);
    rdc(`TMC_OFF_PINFN1, 32'h03);
    apb(1'b0, 8'h3C, 32'h0);
    chk_pin({e, 1'b0}, 2'b10);
    // Low-byte write only reaches the shared buffer, seen through any low byte
    apb(1'b1, `TMC_OFF_CMPA_L, 32'h34);
    rdc(`TMC_OFF_CNT_L, 32'h34);
    apb(1'b1, `TMC_OFF_CMPA_H, 32'h02);
    apb(1'b1, `TMC_OFF_CMPB_L, 32'h77);
    rdc(`TMC_OFF_CMPA_H, 32'h02);
    rdc(`TMC_OFF_CMPA_L, 32'h34);
    // Compare mode only, never capture, so no two inputs are enabled
    apb(1'b1, `TMC_OFF_CTRL1, 32'h01);
    set_cmp(`TMC_OFF_CMPA_L, 10'h005);
    set_cmp(`TMC_OFF_CMPB_L, 10'h002);
    set_cmp(`TMC_OFF_CMPP_L, 10'h003);
    // Match period for clock-source codes 0 to 5, reserved code last
    for (i = 0; i < 6; i++) begin
      apb(1'b1, `TMC_OFF_CTRL0, {24'h0, 1'b0, rows[i].cks, 4'h8});
      gap(0, 2000, n);
      if (rows[i].gap != 0) gap(0, 2000, n);
      chk_val(n, rows[i].gap);
    end
    // All three comparators raise their own pulse at their own count
    apb(1'b1, `TMC_OFF_CTRL0, 32'h18);
    gap(0, 100, n);
    gap(2, 100, n);
    chk_val(n, 4);
    gap(0, 100, n);
    gap(1, 100, n);
    chk_val(n, 3);
    // Output actions: low, high, toggle; complementary pair via inversion bits
    apb(1'b1, `TMC_OFF_OUTINV, 32'h02);
    for (i = 1; i < 4; i++) begin
      apb(1'b1, `TMC_OFF_CTRL0, 32'h00);
      apb(1'b1, `TMC_OFF_CTRL1, {24'h0, 2'b00, i[1:0], (i == 1), 3'b001});
      apb(1'b1, `TMC_OFF_CTRL0, 32'h08);
      repeat (4) @(posedge core_clk);
      chk_pin(tpin, (i == 1) ? 2'b01 : 2'b10);
      gap(0, 100, n);
      repeat (3) @(posedge core_clk);
      chk_pin(tpin, (i == 1) ? 2'b10 : 2'b01);
      chk_pin(pad, tpin);
    end
    gap(0, 100, n);
    repeat (3) @(posedge core_clk);
    chk_pin(tpin, 2'b10);
    // Disabling pin 1 leaves it with its other function
    apb(1'b1, `TMC_OFF_PINFN0, 32'h80);
    repeat (2) @(posedge core_clk);
    chk_pin(toe, 2'b01);
    chk_pin({pad[1], 1'b0}, 2'b10);
    // PWM on the same pin: high three ticks out of eight
    apb(1'b1, `TMC_OFF_OUTINV, 32'h00);
    apb(1'b1, `TMC_OFF_CTRL0, 32'h00);
    apb(1'b1, `TMC_OFF_CTRL1, 32'h88);
    set_cmp(`TMC_OFF_CMPP_L, 10'h007);
    set_cmp(`TMC_OFF_CMPA_L, 10'h003);
    apb(1'b1, `TMC_OFF_CTRL0, 32'h18);
    gap(2, 100, n);
    hi = 0;
    repeat (80) begin
      @(posedge core_clk);
      if (tpin[0] === 1'b1) hi++;
    end
    chk_val(hi, 30);
    // External pin: one count per qualifying edge, rising then falling
    apb(1'b1, `TMC_OFF_CTRL0, 32'h00);
    apb(1'b1, `TMC_OFF_CTRL1, 32'h01);
    set_cmp(`TMC_OFF_CMPA_L, 10'h3FF);
    apb(1'b1, `TMC_OFF_CTRL0, 32'h68);
    src.burst(7);
    rdc(`TMC_OFF_CNT_H, 32'h00);
    rdc(`TMC_OFF_CNT_L, 32'h07);
    apb(1'b1, `TMC_OFF_CTRL0, 32'h78);
    src.burst(5);
    rdc(`TMC_OFF_CNT_H, 32'h00);
    rdc(`TMC_OFF_CNT_L, 32'h0C);
    // Reserved code selected: pin edges must not reach the counter
    apb(1'b1, `TMC_OFF_CTRL0, 32'h58);
    src.burst(4);
    rdc(`TMC_OFF_CNT_H, 32'h00);
    rdc(`TMC_OFF_CNT_L, 32'h0C);
    // Mid-run reset restores the pin enables and empties the shared buffer
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    rdc(`TMC_OFF_PINFN0, 32'h91);
    chk_pin(toe, 2'b11);
    rdc(`TMC_OFF_CNT_L, 32'h00);
    results();
  end
endmodule
`default_nettype wire

/* sim/tmc_ext_src.sv */
// Far-side model of the timer block: internal clock strobes, external clock pin, pin loads.
// Assumes one core_clk domain; burst() moves the external pin just after clock edges.
`timescale 1ns/10ps
`default_nettype none
module tmc_ext_src (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  output var  logic       high_clk_tick,
  output var  logic       time_base_clock,
  output var  logic       timer_ext_clock_pin,
  input  wire logic [1:0] timer_output_pin,
  input  wire logic [1:0] timer_output_oe,
  output logic      [1:0] pad_level
);
  logic [1:0] hc;
  logic [2:0] tb;

  // High clock strobe every 2 cycles, time-base strobe every 5 cycles
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      hc              <= 2'h0;
      tb              <= 3'h0;
      high_clk_tick   <= 1'b0;
      time_base_clock <= 1'b0;
    end else begin
      hc              <= (hc == 2'h1) ? 2'h0 : hc + 2'h1;
      tb              <= (tb == 3'h4) ? 3'h0 : tb + 3'h1;
      high_clk_tick   <= (hc == 2'h1);
      time_base_clock <= (tb == 3'h4);
    end
  end

  // Pin stands still at low between bursts, so no stray edge on a source change
  initial timer_ext_clock_pin = 1'b0;

  // Three cycles high, three low, so the synchroniser sees every edge
  task automatic burst(input int n);
    repeat (n) begin
      repeat (3) @(posedge core_clk);
      timer_ext_clock_pin <= 1'b1;
      repeat (3) @(posedge core_clk);
      timer_ext_clock_pin <= 1'b0;
    end
    repeat (4) @(posedge core_clk);
  endtask

  // Pin keeps its pull-up level while the timer does not own it
  assign pad_level[0] = timer_output_oe[0] ? timer_output_pin[0] : 1'b1;
  assign pad_level[1] = timer_output_oe[1] ? timer_output_pin[1] : 1'b1;
endmodule
`default_nettype wire
